// ### verilog/bbrx_pkg.sv
package bbrx_pkg;
	// ************************************************
	// Register indices (byte address = index * 4)
	// ************************************************
	localparam logic [7:0] IDX_SEED_CHOICE = 8'h0a;
	localparam logic [7:0] IDX_MP_THRESH   = 8'h48;
	localparam logic [7:0] IDX_LONG_SEED   = 8'h60;
	localparam logic [7:0] IDX_SHORT_SEED  = 8'h62;
	localparam logic [7:0] IDX_TEST_BUS    = 8'h64;
	localparam logic [7:0] IDX_QUAL_NOISEA = 8'h66;
	localparam logic [7:0] IDX_SIG_NOISEB  = 8'h68;
	localparam logic [7:0] IDX_SERV_IDC    = 8'h6a;
	localparam logic [7:0] IDX_LENL_QDC    = 8'h6c;
	localparam logic [7:0] IDX_LENH_MP     = 8'h6e;
	localparam logic [7:0] IDX_CRCL_MPCNT  = 8'h70;
	localparam logic [7:0] IDX_CRCH_QUAL   = 8'h72;
	localparam logic [7:0] IDX_TX_POWER    = 8'h74;
	localparam logic [7:0] IDX_UNUSED_SLOT = 8'h76;
	localparam logic [7:0] IDX_MEAN_POWER  = 8'h78;
	localparam logic [7:0] IDX_RX_FLAGS    = 8'h7c;

	// ************************************************
	// Fields and reset values
	// ************************************************
	localparam int         SEED_CHOICE_BIT = 3;
	localparam int         VIEW_BIT        = 7;
	localparam int         SEM_BIT         = 3;
	localparam int         MP_THR_HI       = 7;
	localparam int         MP_THR_LO       = 5;
	localparam int         MP_HISTORY      = 15;
	localparam int         TXP_AVG_LOG2    = 6;
	localparam logic [5:0] TXP_LAST        = 6'h3f;
	localparam logic [7:0] RESET_BYTE      = 8'h00;

	// ************************************************
	// Receive front end values
	// ************************************************
	typedef struct packed {
		logic [7:0]  test_bus;
		logic [7:0]  noise_a;
		logic [7:0]  noise_b;
		logic [7:0]  snr_quality;
		logic [7:0]  signal_field;
		logic [7:0]  service_field;
		logic [7:0]  i_dc;
		logic [7:0]  q_dc;
		logic [15:0] length;
		logic [15:0] header_crc;
		logic [7:0]  mean_power;
		logic [7:0]  mp_metric;
		logic [7:0]  pkt_quality;
		logic        pkt_done;
		logic        rx_active;
		logic [7:0]  txp_sample;
		logic        txp_valid;
	} bbrx_fe_t;
endpackage

// ### verilog/bbrx_regs.sv
// Function
// - Long preamble seed held in bits 6:0
// - Short preamble seed held in bits 6:0
// - Choice bit selects which seed is used
// - View bit picks first or second view
// - Test bus value read in both views
// - Noise A or loop SNR quality
// - Noise B or received signal field
// - I DC offset or service field
// - Q DC offset or length low byte
// - Multipath metric or length high byte
// - Multipath count of 15 or CRC low
// - Quality after receive ends or CRC high
// - Transmit power, 64 sample signed average
// - Status bit flags unread power update
// - Mean received power in second view
`timescale 1ns/1ps
module bbrx_regs (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [11:0]       paddr,
	input  wire logic [31:0]       pwdata,
	output logic                   pready,
	output logic [31:0]            prdata,
	output logic                   pslverr,
	input  wire bbrx_pkg::bbrx_fe_t fe,
	output logic [6:0]             scrambler_seed
);
	// ************************************************
	// Decode helpers
	// ************************************************
	function automatic logic [11:0] byte_addr(input logic [7:0] idx);
		return {2'b00, idx, 2'b00};
	endfunction

	function automatic logic is_reg(input logic [11:0] a, input logic [7:0] idx);
		return a == byte_addr(idx);
	endfunction

	function automatic logic [3:0] ones(input logic [14:0] v);
		logic [3:0] n;
		n = 4'h0;
		for (int k = 0; k < bbrx_pkg::MP_HISTORY; k++) begin
			n = n + {3'b000, v[k]};
		end
		return n;
	endfunction

	logic [7:0]  long_seed;
	logic [7:0]  short_seed;
	logic [7:0]  seed_choice;
	logic [7:0]  mp_thresh;
	logic [7:0]  mp_latched;
	logic [7:0]  quality;
	logic        rx_active_q;
	logic [14:0] mp_hist;
	logic [5:0]  txp_cnt;
	logic [13:0] txp_acc;
	logic [7:0]  tx_power;
	logic        txp_sem;
	logic        view_a;
	logic        setup;
	logic        access;
	logic        wr;
	logic        hit;
	logic        txp_done;
	logic        txp_read;
	logic [13:0] next_acc;
	logic [7:0]  rd_byte;

	assign setup  = psel && !penable;
	assign access = psel && penable;
	assign wr     = access && pwrite;
	assign view_a = short_seed[bbrx_pkg::VIEW_BIT];

	// ************************************************
	// Bus slave
	// ************************************************
	// Zero wait states: read data is fetched in the setup cycle
	assign pready = 1'b1;

	always_comb begin
		hit = is_reg(paddr, bbrx_pkg::IDX_SEED_CHOICE) ||
		      is_reg(paddr, bbrx_pkg::IDX_MP_THRESH) ||
		      is_reg(paddr, bbrx_pkg::IDX_RX_FLAGS) ||
		      (paddr[1:0] == 2'b00 &&
		       paddr[9:2] >= bbrx_pkg::IDX_LONG_SEED &&
		       paddr[9:2] <= bbrx_pkg::IDX_MEAN_POWER &&
		       !paddr[2] && paddr[11:10] == 2'b00 &&
		       !is_reg(paddr, bbrx_pkg::IDX_UNUSED_SLOT));
	end

	assign pslverr = access && !hit;

	always_comb begin
		rd_byte = bbrx_pkg::RESET_BYTE;
		case (paddr)
			byte_addr(bbrx_pkg::IDX_SEED_CHOICE): rd_byte = seed_choice;
			byte_addr(bbrx_pkg::IDX_MP_THRESH):   rd_byte = mp_thresh;
			byte_addr(bbrx_pkg::IDX_LONG_SEED):   rd_byte = long_seed;
			byte_addr(bbrx_pkg::IDX_SHORT_SEED):  rd_byte = short_seed;
			byte_addr(bbrx_pkg::IDX_TEST_BUS):    rd_byte = fe.test_bus;
			// Each read-only register from noise A to CRC high shows view a or b
			byte_addr(bbrx_pkg::IDX_QUAL_NOISEA): begin
				rd_byte = view_a ? fe.noise_a : fe.snr_quality;
			end
			byte_addr(bbrx_pkg::IDX_SIG_NOISEB): begin
				rd_byte = view_a ? fe.noise_b : fe.signal_field;
			end
			byte_addr(bbrx_pkg::IDX_SERV_IDC): begin
				rd_byte = view_a ? fe.i_dc : fe.service_field;
			end
			byte_addr(bbrx_pkg::IDX_LENL_QDC): begin
				rd_byte = view_a ? fe.q_dc : fe.length[7:0];
			end
			byte_addr(bbrx_pkg::IDX_LENH_MP): begin
				rd_byte = view_a ? mp_latched : fe.length[15:8];
			end
			byte_addr(bbrx_pkg::IDX_CRCL_MPCNT): begin
				rd_byte = view_a ? {4'h0, ones(mp_hist)} : fe.header_crc[7:0];
			end
			byte_addr(bbrx_pkg::IDX_CRCH_QUAL): begin
				rd_byte = view_a ? quality : fe.header_crc[15:8];
			end
			byte_addr(bbrx_pkg::IDX_TX_POWER):    rd_byte = tx_power;
			byte_addr(bbrx_pkg::IDX_MEAN_POWER): begin
				rd_byte = view_a ? bbrx_pkg::RESET_BYTE : fe.mean_power;
			end
			byte_addr(bbrx_pkg::IDX_RX_FLAGS): begin
				rd_byte = bbrx_pkg::RESET_BYTE;
				rd_byte[bbrx_pkg::SEM_BIT] = txp_sem;
			end
			default: rd_byte = bbrx_pkg::RESET_BYTE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (setup) begin
			prdata <= {24'h00_0000, rd_byte};
		end
	end

	// ************************************************
	// Writable registers
	// ************************************************
	// Only these four decode for write; others drop it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			long_seed   <= bbrx_pkg::RESET_BYTE;
			short_seed  <= bbrx_pkg::RESET_BYTE;
			seed_choice <= bbrx_pkg::RESET_BYTE;
			mp_thresh   <= bbrx_pkg::RESET_BYTE;
		end else if (wr) begin
			// Long seed bit 7 is stored but drives nothing; short seed bit 7 picks the view
			if (is_reg(paddr, bbrx_pkg::IDX_LONG_SEED)) begin
				long_seed <= pwdata[7:0];
			end
			if (is_reg(paddr, bbrx_pkg::IDX_SHORT_SEED)) begin
				short_seed <= pwdata[7:0];
			end
			if (is_reg(paddr, bbrx_pkg::IDX_SEED_CHOICE)) begin
				seed_choice <= pwdata[7:0];
			end
			if (is_reg(paddr, bbrx_pkg::IDX_MP_THRESH)) begin
				mp_thresh <= pwdata[7:0];
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scrambler_seed <= 7'h00;
		end else if (seed_choice[bbrx_pkg::SEED_CHOICE_BIT]) begin
			scrambler_seed <= short_seed[6:0];
		end else begin
			scrambler_seed <= long_seed[6:0];
		end
	end

	// ************************************************
	// Packet measurements
	// ************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mp_latched <= bbrx_pkg::RESET_BYTE;
			mp_hist    <= 15'h0000;
		end else if (fe.pkt_done) begin
			mp_latched <= fe.mp_metric;
			mp_hist    <= {mp_hist[13:0],
				fe.mp_metric[bbrx_pkg::MP_THR_HI:bbrx_pkg::MP_THR_LO] >
				mp_thresh[bbrx_pkg::MP_THR_HI:bbrx_pkg::MP_THR_LO]};
		end
	end

	// Latched as receive ends so a read never sees a half-built value
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_active_q <= 1'b0;
			quality     <= bbrx_pkg::RESET_BYTE;
		end else begin
			rx_active_q <= fe.rx_active;
			if (rx_active_q && !fe.rx_active) begin
				quality <= fe.pkt_quality;
			end
		end
	end

	// ************************************************
	// Transmit power average
	// ************************************************
	assign next_acc = txp_acc + {{6{fe.txp_sample[7]}}, fe.txp_sample};
	assign txp_done = fe.txp_valid && txp_cnt == bbrx_pkg::TXP_LAST;
	assign txp_read = access && !pwrite && is_reg(paddr, bbrx_pkg::IDX_TX_POWER);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			txp_cnt  <= 6'h00;
			txp_acc  <= 14'h0000;
			tx_power <= bbrx_pkg::RESET_BYTE;
		end else if (fe.txp_valid) begin
			txp_cnt <= txp_cnt + 6'h01;
			if (txp_done) begin
				// Arithmetic shift keeps the sign of the mean
				tx_power <= next_acc[bbrx_pkg::TXP_AVG_LOG2 +: 8];
				txp_acc  <= 14'h0000;
			end else begin
				txp_acc <= next_acc;
			end
		end
	end

	// A new average in the same cycle as the read keeps the flag set
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			txp_sem <= 1'b0;
		end else if (txp_done) begin
			txp_sem <= 1'b1;
		end else if (txp_read) begin
			txp_sem <= 1'b0;
		end
	end

	// ************************************************
	// Assertions
	// ************************************************
	sequence s_rd_setup(logic [7:0] idx);
		setup && !pwrite && is_reg(paddr, idx);
	endsequence

	sequence s_avg_end;
		txp_done;
	endsequence

	a_seed_follow: assert property (@(posedge pclk) disable iff (!presetn)
		##1 scrambler_seed == ($past(seed_choice[bbrx_pkg::SEED_CHOICE_BIT]) ?
		$past(short_seed[6:0]) : $past(long_seed[6:0])))
		else $error("scrambler seed does not follow choice bit");

	a_view_noise_a: assert property (@(posedge pclk) disable iff (!presetn)
		s_rd_setup(bbrx_pkg::IDX_QUAL_NOISEA) |=> prdata[7:0] ==
		($past(view_a) ? $past(fe.noise_a) : $past(fe.snr_quality)))
		else $error("signal quality view wrong");

	a_view_length: assert property (@(posedge pclk) disable iff (!presetn)
		s_rd_setup(bbrx_pkg::IDX_LENL_QDC) |=> prdata[7:0] ==
		($past(view_a) ? $past(fe.q_dc) : $past(fe.length[7:0])))
		else $error("length low view wrong");

	a_test_bus: assert property (@(posedge pclk) disable iff (!presetn)
		s_rd_setup(bbrx_pkg::IDX_TEST_BUS) |=> prdata == {24'h00_0000, $past(fe.test_bus)})
		else $error("test bus readback wrong");

	a_ro_ignore: assert property (@(posedge pclk) disable iff (!presetn)
		wr && is_reg(paddr, bbrx_pkg::IDX_CRCH_QUAL) && !(rx_active_q && !fe.rx_active)
		|=> quality == $past(quality))
		else $error("write changed read-only value");

	a_quality_hold: assert property (@(posedge pclk) disable iff (!presetn)
		fe.rx_active && rx_active_q [*2] |-> $stable(quality))
		else $error("quality moved during receive");

	a_sem_set: assert property (@(posedge pclk) disable iff (!presetn)
		s_avg_end |=> txp_sem ##0 tx_power == $past(next_acc[13:6]))
		else $error("average end did not flag update");

	a_sem_clear: assert property (@(posedge pclk) disable iff (!presetn)
		txp_read && !txp_done |=> !txp_sem)
		else $error("read did not clear power flag");

	a_avg_span: assert property (@(posedge pclk) disable iff (!presetn)
		s_avg_end |=> txp_cnt == 6'h00 && txp_acc == 14'h0000)
		else $error("average window not 64 samples");

	a_mp_shift: assert property (@(posedge pclk) disable iff (!presetn)
		fe.pkt_done |=> mp_hist[14:1] == $past(mp_hist[13:0]) && mp_latched == $past(fe.mp_metric))
		else $error("multipath history not updated");

	a_slverr_map: assert property (@(posedge pclk) disable iff (!presetn)
		access && is_reg(paddr, bbrx_pkg::IDX_SHORT_SEED) |-> !pslverr && pready)
		else $error("mapped register answered with error");

	a_view_noise_b: assert property (@(posedge pclk) disable iff (!presetn)
		s_rd_setup(bbrx_pkg::IDX_SIG_NOISEB) |=> prdata[7:0] ==
		($past(view_a) ? $past(fe.noise_b) : $past(fe.signal_field)))
		else $error("signal field view wrong");

	a_view_service: assert property (@(posedge pclk) disable iff (!presetn)
		s_rd_setup(bbrx_pkg::IDX_SERV_IDC) |=> prdata[7:0] ==
		($past(view_a) ? $past(fe.i_dc) : $past(fe.service_field)))
		else $error("service field view wrong");

	a_view_len_high: assert property (@(posedge pclk) disable iff (!presetn)
		s_rd_setup(bbrx_pkg::IDX_LENH_MP) |=> prdata[7:0] ==
		($past(view_a) ? $past(mp_latched) : $past(fe.length[15:8])))
		else $error("length high view wrong");

	a_view_crc_low: assert property (@(posedge pclk) disable iff (!presetn)
		s_rd_setup(bbrx_pkg::IDX_CRCL_MPCNT) ##0 !view_a |=>
		prdata[7:0] == $past(fe.header_crc[7:0]))
		else $error("header crc low view wrong");

	a_mp_count_range: assert property (@(posedge pclk) disable iff (!presetn)
		s_rd_setup(bbrx_pkg::IDX_CRCL_MPCNT) ##0 view_a |=>
		prdata[7:4] == 4'h0)
		else $error("multipath count out of range");

	a_view_crc_high: assert property (@(posedge pclk) disable iff (!presetn)
		s_rd_setup(bbrx_pkg::IDX_CRCH_QUAL) |=> prdata[7:0] ==
		($past(view_a) ? $past(quality) : $past(fe.header_crc[15:8])))
		else $error("header crc high view wrong");

	a_quality_latch: assert property (@(posedge pclk) disable iff (!presetn)
		rx_active_q && !fe.rx_active |=> quality == $past(fe.pkt_quality))
		else $error("quality not taken as receive ended");

	a_tx_power_rd: assert property (@(posedge pclk) disable iff (!presetn)
		s_rd_setup(bbrx_pkg::IDX_TX_POWER) |=> prdata[7:0] == $past(tx_power))
		else $error("transmit power readback wrong");

	a_mean_power: assert property (@(posedge pclk) disable iff (!presetn)
		s_rd_setup(bbrx_pkg::IDX_MEAN_POWER) ##0 !view_a |=>
		prdata[7:0] == $past(fe.mean_power))
		else $error("mean power view wrong");

	a_long_seed_wr: assert property (@(posedge pclk) disable iff (!presetn)
		wr && is_reg(paddr, bbrx_pkg::IDX_LONG_SEED) |=>
		long_seed == $past(pwdata[7:0]))
		else $error("long seed write lost");

	a_short_seed_wr: assert property (@(posedge pclk) disable iff (!presetn)
		wr && is_reg(paddr, bbrx_pkg::IDX_SHORT_SEED) |=>
		short_seed == $past(pwdata[7:0]))
		else $error("short seed write lost");

	a_bad_addr_err: assert property (@(posedge pclk) disable iff (!presetn)
		access && paddr[1:0] != 2'b00 |-> pslverr)
		else $error("unaligned access not refused");

	a_ro_write_ok: assert property (@(posedge pclk) disable iff (!presetn)
		wr && is_reg(paddr, bbrx_pkg::IDX_TEST_BUS) |-> !pslverr)
		else $error("read-only write answered with error");

	a_sem_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!txp_done && !txp_read |=> txp_sem == $past(txp_sem))
		else $error("power flag moved without cause");
endmodule

// ### testbench/bbrx_apb_ctl.sv
`timescale 1ns/1ps
module bbrx_apb_ctl (
	input  wire logic        pclk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [11:0]      paddr,
	output logic [31:0]      pwdata,
	input  wire logic        pready
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
	end

	// One idle edge before each setup, so psel is never assigned twice in a step
	task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule

// ### testbench/tb_bbrx_regs.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks++; if ((e) !== (s)) begin errors++; \
	$display("[FAIL] %s exp %h got %h", n, e, s); end end
module tb_bbrx_regs;
	logic                pclk = 1'b0;
	logic                presetn = 1'b0;
	logic                psel, penable, pwrite, pready, pslverr;
	logic [11:0]         paddr;
	logic [31:0]         pwdata, prdata;
	logic [6:0]          seed;
	bbrx_pkg::bbrx_fe_t  fe = '0;
	int                  errors = 0;
	int                  checks = 0;
	int                  seed_v = 28;
	int                  sum;
	logic [32:0]         q[$];
	logic [32:0]         note;
	logic [7:0]          r[13];
	logic [7:0]          mp, qual, txp, cnt, s;
	logic [14:0]         hist;

	always #2.5 pclk = ~pclk;

	bbrx_regs i_bbrx_regs (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .fe(fe), .scrambler_seed(seed));
	bbrx_apb_ctl i_bbrx_apb_ctl (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pready(pready));

	task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic err);
		q.push_back({err, 24'h000000, e});
		i_bbrx_apb_ctl.xfer(1'b0, a, 8'h00);
	endtask

	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		i_bbrx_apb_ctl.xfer(1'b1, a, d);
	endtask

	task wrap_up;
		$display("errors=%0d checks=%0d", errors, checks);
		if (errors == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Reads are judged at the access edge, in issue order
	always @(posedge pclk) if (psel && penable && pready && !pwrite) begin
		note = q.pop_front();
		`CHK("prdata", note[31:0], prdata)
		`CHK("pslverr", note[32], pslverr)
	end

	initial begin
		repeat (5000) @(posedge pclk);
		errors++;
		wrap_up();
	end

	// ************************************************
	// Main sequence
	// ************************************************
	initial begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rd(12'h180, 8'h00, 1'b0);
		wr(12'h180, 8'h5a);
		wr(12'h188, 8'h33);
		repeat (2) @(posedge pclk);
		`CHK("seed", 7'h5a, seed)
		wr(12'h028, 8'h08);
		repeat (2) @(posedge pclk);
		`CHK("seed", 7'h33, seed)
		rd(12'h188, 8'h33, 1'b0);
		wr(12'h1d8, 8'hff);
		rd(12'h1d8, 8'h00, 1'b1);
		rd(12'h182, 8'h00, 1'b1);
		wr(12'h120, 8'h60);
		hist = '0;
		for (int i = 0; i < 17; i++) begin
			@(posedge pclk);
			mp = 8'($random(seed_v));
			fe.mp_metric <= mp;
			fe.pkt_done <= 1'b1;
			hist = {hist[13:0], mp[7:5] > 3'd3};
			@(posedge pclk);
			fe.pkt_done <= 1'b0;
		end
		cnt = 8'($countones(hist));
		qual = 8'($random(seed_v));
		// Quality moves while receive runs; only the value at its end counts
		@(posedge pclk);
		fe.rx_active <= 1'b1;
		fe.pkt_quality <= ~qual;
		repeat (2) @(posedge pclk);
		fe.pkt_quality <= qual;
		@(posedge pclk);
		fe.rx_active <= 1'b0;
		repeat (2) @(posedge pclk);
		fe.pkt_quality <= ~qual;
		sum = 0;
		for (int i = 0; i < 64; i++) begin
			@(posedge pclk);
			s = 8'($random(seed_v));
			sum += int'($signed(s));
			fe.txp_sample <= s;
			fe.txp_valid <= 1'b1;
		end
		@(posedge pclk);
		fe.txp_valid <= 1'b0;
		txp = 8'(sum >>> 6);
		rd(12'h1f0, 8'h08, 1'b0);
		rd(12'h1d0, txp, 1'b0);
		rd(12'h1f0, 8'h00, 1'b0);
		for (int v = 1; v >= 0; v--) begin
			for (int k = 0; k < 13; k++) r[k] = 8'($random(seed_v));
			{fe.test_bus, fe.noise_a, fe.noise_b, fe.snr_quality, fe.signal_field, fe.service_field,
				fe.i_dc, fe.q_dc, fe.length, fe.header_crc, fe.mean_power} <=
				{r[0], r[1], r[2], r[3], r[4], r[5], r[6], r[7], r[9], r[8], r[11], r[10], r[12]};
			wr(12'h188, {v[0], 7'h33});
			rd(12'h190, r[0], 1'b0);
			rd(12'h198, v ? r[1] : r[3], 1'b0);
			rd(12'h1a0, v ? r[2] : r[4], 1'b0);
			rd(12'h1a8, v ? r[6] : r[5], 1'b0);
			rd(12'h1b0, v ? r[7] : r[8], 1'b0);
			rd(12'h1b8, v ? mp : r[9], 1'b0);
			rd(12'h1c0, v ? cnt : r[10], 1'b0);
			wr(12'h1c8, 8'h5a);
			rd(12'h1c8, v ? qual : r[11], 1'b0);
			rd(12'h1d0, txp, 1'b0);
			rd(12'h1e0, v ? 8'h00 : r[12], 1'b0);
			wr(12'h190, 8'hff);
			rd(12'h190, r[0], 1'b0);
		end
		repeat (2) @(posedge pclk);
		wrap_up();
	end
endmodule
